/* File: hdl/slave_i2c_control_status.sv */
// slave two-wire control/status block: cpu registers plus link-side bit engine
// assumes scl/sda arrive asynchronous, link_clk oversamples them, tx_data held while pending
// What this block does
// RULE1 - the own-address register keeps a 7-bit address in bits 7..1 and bit 0 reads zero.
// RULE2 - the own address is compared only against the address byte, never against data bytes.
// RULE3 - own-address writes land only while the module enable bit is 0; reads always work.
// RULE4 - the interrupt enable bit gates the transfer interrupt request.
// RULE5 - pending reads 0 when nothing is pending and writing 0 to it clears it.
// RULE6 - pending is set whenever one byte has been sent or received.
// RULE7 - pending is set when a received address byte matches the own address.
// RULE8 - the direction bit selects receive when 0 (reset value) and transmit when 1.
// RULE9 - bus busy, address match and received acknowledge are read-only status bits.
// RULE10 - address match clears on start, stop and reset and sets on an address hit.
// RULE11 - with acknowledge enabled the ninth clock of each received byte is acknowledged.
// RULE12 - in transmit the ninth-clock data level is stored as the received-acknowledge bit.
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // plain two-stage synchroniser; meta_reg feeds nothing else
  // reset value is the source's idle level so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

module slave_i2c_control_status (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // cpu register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // data bytes and interrupt
  input wire logic [7:0] tx_data,
  output logic [7:0] rx_data,
  output logic irq,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import slave_i2c_pkg::*;

  logic [7:0] ctl_reg, ctl_next;
  logic [6:0] own_reg, own_next;
  logic [7:0] rdata_next;
  logic irq_next;
  link_stat_s stat_q;
  logic byte_tgl_d, match_tgl_d;
  link_cfg_s cfg_l;
  logic [1:0] pin_q;
  logic scl_d, sda_d;
  link_state_e state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] shreg_reg, rx_byte_reg;
  logic half_reg, busy_reg, match_reg, rx_ack_reg, byte_tgl_reg, match_tgl_reg;

  // cpu side decode
  wire wr_ctl = reg_wr && (reg_addr == OFF_CONTROL_STATUS);
  wire rd_ctl = reg_rd && (reg_addr == OFF_CONTROL_STATUS);
  wire rd_own = reg_rd && (reg_addr == OFF_OWN_ADDRESS);
  wire wr_own = reg_wr && (reg_addr == OFF_OWN_ADDRESS) && !ctl_reg[BIT_MODULE_EN]; // [RULE3]
  wire byte_ev = stat_q.byte_tgl ^ byte_tgl_d;
  wire match_ev = stat_q.match_tgl ^ match_tgl_d;
  wire pend_clr = wr_ctl && !reg_wdata[BIT_PENDING]; // [RULE5]
  // a new event beats a simultaneous software clear
  wire pend_next = byte_ev || match_ev || (ctl_reg[BIT_PENDING] && !pend_clr); // [RULE6] [RULE7]
  wire [7:0] ctl_kept = (wr_ctl ? reg_wdata : ctl_reg) & CTL_WRITE_MASK; // [RULE9]
  wire [7:0] ctl_view = {ctl_reg[7:3], stat_q.busy, stat_q.match, stat_q.rx_ack};

  // next values of cpu side registers
  always_comb begin
    ctl_next = ctl_kept;
    ctl_next[BIT_PENDING] = pend_next;
    own_next = wr_own ? reg_wdata[7:1] : own_reg; // [RULE1]
    rdata_next = rd_ctl ? ctl_view : (rd_own ? {own_reg, 1'b0} : 8'h00); // [RULE1]
    irq_next = ctl_reg[BIT_IRQ_EN] && ctl_reg[BIT_PENDING]; // [RULE4]
  end

  // cpu side registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= CTL_RESET;
      own_reg <= OWN_ADDRESS_RESET;
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      byte_tgl_d <= 1'b0;
      match_tgl_d <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      ctl_reg <= ctl_next;
      own_reg <= own_next;
      reg_rdata <= rdata_next;
      irq <= irq_next;
      byte_tgl_d <= stat_q.byte_tgl;
      match_tgl_d <= stat_q.match_tgl;
      // rx_byte_reg is frozen for a whole byte time around its toggle
      if (byte_ev) begin
        rx_data <= rx_byte_reg;
      end
    end
  end

  // crossings: settings are quasi-static, status levels and toggles go two-flop
  sync2 #(.WIDTH($bits(link_cfg_s))) cfg_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d({ctl_reg[BIT_ACK_EN], ctl_reg[BIT_MODULE_EN], ctl_reg[BIT_DIRECTION], own_reg, tx_data}),
    .q(cfg_l)
  );
  sync2 #(.WIDTH($bits(link_stat_s))) stat_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({busy_reg, match_reg, rx_ack_reg, byte_tgl_reg, match_tgl_reg}),
    .q(stat_q)
  );
  // bus lines idle high, matching the reset of scl_d and sda_d
  sync2 #(.WIDTH(2), .INIT(2'h3)) pin_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in}),
    .q(pin_q)
  );

  // link side bus event decode
  wire scl = pin_q[1];
  wire sda = pin_q[0];
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_det = scl && scl_d && sda_d && !sda;
  wire stop_det = scl && scl_d && !sda_d && sda;
  wire last_bit = (cnt_reg == LAST_BIT);
  wire [7:0] byte_in = {shreg_reg[6:0], sda};
  wire addr_hit = (shreg_reg[6:0] == cfg_l.own_address) || (shreg_reg[6:0] == GENERAL_CALL);

  assign sda_out = 1'b0; // open drain: only the enable moves

  // link side bit engine; the device never stretches scl
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      shreg_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      half_reg <= 1'b0;
      busy_reg <= 1'b0;
      match_reg <= 1'b0;
      rx_ack_reg <= 1'b0;
      byte_tgl_reg <= 1'b0;
      match_tgl_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (start_det || stop_det) begin
        state_reg <= start_det ? ST_ADDR : ST_IDLE;
        busy_reg <= start_det;
        match_reg <= 1'b0; // [RULE10]
        cnt_reg <= 3'h0;
        half_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (!cfg_l.module_en) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shreg_reg <= byte_in;
              cnt_reg <= cnt_reg + 3'h1;
              if (last_bit && state_reg == ST_ADDR) begin
                // compare happens only here, never on data bytes
                if (addr_hit) begin // [RULE2]
                  match_reg <= 1'b1; // [RULE10]
                  match_tgl_reg <= !match_tgl_reg; // [RULE7]
                  state_reg <= ST_ACK_A;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (last_bit) begin
                rx_byte_reg <= byte_in;
                byte_tgl_reg <= !byte_tgl_reg; // [RULE6]
                state_reg <= ST_ACK_R;
              end
            end
          end
          ST_ACK_A, ST_ACK_R: begin
            if (scl_fall && !half_reg) begin
              sda_oe <= cfg_l.ack_en; // [RULE11]
              half_reg <= 1'b1;
            end else if (scl_fall) begin
              half_reg <= 1'b0;
              cnt_reg <= 3'h0;
              if (state_reg == ST_ACK_A && cfg_l.direction) begin // [RULE8]
                sda_oe <= !cfg_l.tx_byte[7];
                shreg_reg <= {cfg_l.tx_byte[6:0], 1'b0};
                state_reg <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              sda_oe <= !shreg_reg[7];
              shreg_reg <= {shreg_reg[6:0], 1'b0};
            end else if (scl_rise) begin
              cnt_reg <= cnt_reg + 3'h1;
              if (last_bit) begin
                state_reg <= ST_ACK_T;
              end
            end
          end
          ST_ACK_T: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
            end else if (scl_rise) begin
              rx_ack_reg <= sda; // [RULE12]
              byte_tgl_reg <= !byte_tgl_reg; // [RULE6]
              state_reg <= ST_WAIT_T;
            end
          end
          ST_WAIT_T: begin
            if (scl_fall && rx_ack_reg) begin
              state_reg <= ST_IDLE;
            end else if (scl_fall) begin
              sda_oe <= !cfg_l.tx_byte[7];
              shreg_reg <= {cfg_l.tx_byte[6:0], 1'b0};
              cnt_reg <= 3'h0;
              state_reg <= ST_TX;
            end
          end
        endcase
      end
    end
  end

  // cpu side checks
  own_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    (reg_wr && reg_addr == OFF_OWN_ADDRESS && ctl_reg[BIT_MODULE_EN]) |=> $stable(own_reg))
    else $error("own address changed while module enabled");
  own_bit0_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
    rd_own |=> (reg_rdata[0] == 1'b0) && (reg_rdata[7:1] == $past(own_reg)))
    else $error("own address read back wrong");
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    irq |-> $past(ctl_reg[BIT_IRQ_EN]) && $past(ctl_reg[BIT_PENDING]))
    else $error("interrupt raised without enable and pending");
  pend_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    (pend_clr && !byte_ev && !match_ev) |=> !ctl_reg[BIT_PENDING] ##1 !irq)
    else $error("pending not cleared by writing zero");
  pend_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
    byte_ev |=> ctl_reg[BIT_PENDING] ##1 (irq == ctl_reg[BIT_IRQ_EN] || !$past(ctl_reg[BIT_IRQ_EN])))
    else $error("byte completion did not set pending");
  pend_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
    match_ev |=> ctl_reg[BIT_PENDING])
    else $error("address match did not set pending");
  status_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
    rd_ctl |=> reg_rdata[2:0] == $past({stat_q.busy, stat_q.match, stat_q.rx_ack}))
    else $error("status bits not taken from the link");

  // link side checks
  dir_tx_a: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE8]
    (state_reg == ST_ACK_A) ##1 (state_reg == ST_TX) |-> $past(cfg_l.direction))
    else $error("transmit entered with receive direction");
  match_clr_a: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE10]
    (start_det || stop_det) |=> !match_reg && !sda_oe)
    else $error("match not cleared on start or stop");
  data_nocmp_a: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE2]
    (state_reg == ST_RX && scl_rise && !start_det && !stop_det) |=> $stable(match_reg))
    else $error("data byte touched address match");
  ack_drive_a: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE11]
    (state_reg == ST_ACK_R && scl_fall && !half_reg && cfg_l.module_en) |=>
    (sda_oe == $past(cfg_l.ack_en)))
    else $error("acknowledge drive does not follow enable");
  rx_ack_a: assert property (@(posedge link_clk) disable iff (!rst_n) // [RULE12]
    (state_reg == ST_ACK_T && scl_rise && cfg_l.module_en) |=>
    (rx_ack_reg == $past(sda)) && (state_reg == ST_WAIT_T))
    else $error("received acknowledge not sampled");

  addr_hit_c: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_reg == ST_ADDR ##1 state_reg == ST_ACK_A);
  rx_byte_c: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_reg == ST_RX ##1 state_reg == ST_ACK_R);
  tx_nack_c: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_reg == ST_WAIT_T && rx_ack_reg ##1 state_reg == ST_IDLE);
  irq_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
endmodule

/* File: hdl/slave_i2c_pkg.sv */
// package for the slave two-wire control and status block
// assumes a cpu register port on ref_clk and a free-running link sampling clock
package slave_i2c_pkg;
  // register offsets in the cpu register space
  localparam logic [7:0] OFF_CONTROL_STATUS = 8'hf2;
  localparam logic [7:0] OFF_OWN_ADDRESS = 8'hf3;
  // control/status field positions
  localparam int BIT_ACK_EN = 7;
  localparam int BIT_MODULE_EN = 6;
  localparam int BIT_IRQ_EN = 5;
  localparam int BIT_PENDING = 4;
  localparam int BIT_DIRECTION = 3;
  // writable control bits: 7, 6, 5 and 3
  localparam logic [7:0] CTL_WRITE_MASK = 8'he8;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [6:0] OWN_ADDRESS_RESET = 7'h00;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_A = 3'h2,
    ST_RX = 3'h3,
    ST_ACK_R = 3'h4,
    ST_TX = 3'h5,
    ST_ACK_T = 3'h6,
    ST_WAIT_T = 3'h7
  } link_state_e;

  // settings handed from the cpu side to the link side
  typedef struct packed {
    logic ack_en;
    logic module_en;
    logic direction;
    logic [6:0] own_address;
    logic [7:0] tx_byte;
  } link_cfg_s;

  // status and event toggles handed from the link side to the cpu side
  typedef struct packed {
    logic busy;
    logic match;
    logic rx_ack;
    logic byte_tgl;
    logic match_tgl;
  } link_stat_s;
endpackage

/* File: testbench/i2c_master_model.sv */
// two-wire bus master model: makes the bus clock and pulls the data line low
// assumes a pull-up in the bench resolves the data line; the clock idles high between frames
`timescale 1ns/1ps
module i2c_master_model (
  // bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam time H = 200; // half bit, well over four link clocks per phase

  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // one bit: data changes mid-low, sampled mid-high, clock left low
  task automatic bit_x(input logic b, output logic r);
    #(H/2) sda_pull = ~b;
    #(H/2) scl = 1'b1;
    #(H/2) r = sda;
    #(H/2) scl = 1'b0;
  endtask

  task automatic start();
    sda_pull = 1'b1;
    #H scl = 1'b0;
  endtask

  // data rises while clock high, then the bus rests
  task automatic stop();
    #(H/2) sda_pull = 1'b1;
    #(H/2) scl = 1'b1;
    #H sda_pull = 1'b0;
    #H;
  endtask

  // byte out msb first, returns the ninth-bit level seen on the line
  task automatic put_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nack);
  endtask

  // byte in msb first, then our own acknowledge level
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, r);
  endtask
endmodule

/* File: testbench/slave_i2c_control_status_tb.sv */
// self-checking bench for the slave two-wire control and status block
// assumes the master model in i2c_master_model.sv and a pull-up on the data line
`timescale 1ns/1ps
module slave_i2c_control_status_tb;
  import slave_i2c_pkg::*;
  logic ref_clk, rst_n, link_clk, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, rx_data, d;
  logic irq, sda_out, sda_oe, scl, sda_pull, b;
  wire sda;
  int fail_count = 0;
  int n_tests = 0;

  // wired-and data line, pulled up when nobody pulls low
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));

  slave_i2c_control_status i_slave_i2c_control_status (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_data(tx_data), .rx_data(rx_data), .irq(irq),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  i2c_master_model i_i2c_master_model (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // clocks with no phase relation
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes launched on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  // read data is valid in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hung bus sequence must not stall the run
  initial begin
    #500000;
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tx_data = 8'hc3; // held for the whole run, so always stable while pending
    // reset is asynchronous, so it clears both domains; release off the cpu edge
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    // reset values, address storage, read-only bits, unmapped place
    rd(OFF_CONTROL_STATUS, 8'h00);
    rd(OFF_OWN_ADDRESS, 8'h00);
    wr(OFF_OWN_ADDRESS, 8'h55);
    rd(OFF_OWN_ADDRESS, 8'h54);
    wr(OFF_CONTROL_STATUS, 8'hf7);
    rd(OFF_CONTROL_STATUS, 8'he0);
    wr(OFF_OWN_ADDRESS, 8'h10);
    rd(OFF_OWN_ADDRESS, 8'h54);
    rd(8'hf5, 8'h00);
    // receive: address hit, then a data byte unlike the address
    i_i2c_master_model.start();
    i_i2c_master_model.put_byte(8'h54, b);
    check({7'h00, b}, 8'h00);
    rd(OFF_CONTROL_STATUS, 8'hf6);
    check({7'h00, irq}, 8'h01);
    wr(OFF_CONTROL_STATUS, 8'he0);
    rd(OFF_CONTROL_STATUS, 8'he6);
    check({7'h00, irq}, 8'h00);
    i_i2c_master_model.put_byte(8'h3c, b);
    check({7'h00, b}, 8'h00);
    check(rx_data, 8'h3c);
    i_i2c_master_model.stop();
    rd(OFF_CONTROL_STATUS, 8'hf0);
    wr(OFF_CONTROL_STATUS, 8'he0);
    // foreign address: no acknowledge, no match, no pending
    i_i2c_master_model.start();
    i_i2c_master_model.put_byte(8'h66, b);
    check({7'h00, b}, 8'h01);
    rd(OFF_CONTROL_STATUS, 8'he4);
    i_i2c_master_model.stop();
    // acknowledge and interrupt disabled
    wr(OFF_CONTROL_STATUS, 8'h40);
    i_i2c_master_model.start();
    i_i2c_master_model.put_byte(8'h54, b);
    check({7'h00, b}, 8'h01);
    rd(OFF_CONTROL_STATUS, 8'h56);
    check({7'h00, irq}, 8'h00);
    i_i2c_master_model.stop();
    // general call: always matches and is acknowledged
    wr(OFF_CONTROL_STATUS, 8'hc0);
    i_i2c_master_model.start();
    i_i2c_master_model.put_byte(8'h00, b);
    check({7'h00, b}, 8'h00);
    rd(OFF_CONTROL_STATUS, 8'hd6);
    i_i2c_master_model.stop();
    // transmit: master acknowledges one byte, refuses the next
    wr(OFF_CONTROL_STATUS, 8'hc8);
    i_i2c_master_model.start();
    i_i2c_master_model.put_byte(8'h55, b);
    check({7'h00, b}, 8'h00);
    i_i2c_master_model.get_byte(1'b0, d);
    check(d, 8'hc3);
    rd(OFF_CONTROL_STATUS, 8'hde);
    i_i2c_master_model.get_byte(1'b1, d);
    check(d, 8'hc3);
    rd(OFF_CONTROL_STATUS, 8'hdf);
    i_i2c_master_model.stop();
    wrap_up();
  end
endmodule
